// File: bench/usb_host_model.sv
/* host traffic and engine event model facing the flag logic.
   assumes the bench calls its tasks from its main sequence. */
`timescale 1ns/1ps
module usb_host_model
  import usb_irq_pkg::*;
(
  input  wire logic i_clk_sys,
  output logic      o_line_dp,
  output logic      o_line_dm,
  output err_evt_t  o_err_evt,
  output sts_evt_t  o_sts_evt
);
  // ----------
  // traffic
  // ----------
  initial begin
    o_line_dp = 1'b1;
    o_line_dm = 1'b0;
    o_err_evt = '0;
    o_sts_evt = '0;
  end
  // toggles the lines each cycle, then idle j as held by the pull-up
  task automatic traffic(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_line_dp <= ~o_line_dp;
      o_line_dm <= ~o_line_dm;
    end
    @(posedge i_clk_sys);
    o_line_dp <= 1'b1;
    o_line_dm <= 1'b0;
  endtask
  // one-cycle engine pulses at the moment of detection
  task automatic pulse(input err_evt_t e, input sts_evt_t s);
    @(posedge i_clk_sys);
    o_err_evt <= e;
    o_sts_evt <= s;
    @(posedge i_clk_sys);
    o_err_evt <= '0;
    o_sts_evt <= '0;
  endtask
endmodule

// File: bench/usb_interrupt_flag_logic_test.sv
/* bench of the usb interrupt flag logic: register and event tests.
   assumes the checker is bound and the host model drives the engine side. */
`timescale 1ns/1ps
module usb_interrupt_flag_logic_test
  import usb_irq_pkg::*;
;
  localparam int          IDLE_N = 50;
  localparam logic [11:0] SE     = IDX_STATUS_ENABLES;
  localparam logic [11:0] EE     = IDX_ERROR_ENABLES;
  localparam logic [11:0] SF     = IDX_STATUS_FLAGS;
  localparam logic [11:0] EF     = IDX_ERROR_FLAGS;
  localparam logic [11:0] CT     = IDX_CONTROL;
  localparam logic [7:0]  ERR_BIT [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
  localparam logic [7:0]  STS_BIT [4] = '{8'h01, 8'h08, 8'h20, 8'h40};
  logic        i_clk_sys;
  logic        i_resetn;
  logic        i_pll_locked;
  avs_req_t    i_avs;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        line_dp;
  logic        line_dm;
  err_evt_t    err_evt;
  sts_evt_t    sts_evt;
  logic        o_usb_irq;
  logic        o_engine_run;
  logic        o_token_reject;
  logic        o_suspend;
  int          err_count;
  int          checks_done;

  usb_interrupt_flag_logic #(.IDLE_COUNT(IDLE_N)) u_usb_interrupt_flag_logic (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_avs(i_avs),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_line_dp(line_dp), .i_line_dm(line_dm), .i_pll_locked(i_pll_locked),
    .i_err_evt(err_evt), .i_sts_evt(sts_evt), .o_usb_irq(o_usb_irq),
    .o_engine_run(o_engine_run), .o_token_reject(o_token_reject), .o_suspend(o_suspend)
  );
  usb_host_model u_usb_host_model (
    .i_clk_sys(i_clk_sys), .o_line_dp(line_dp), .o_line_dm(line_dm),
    .o_err_evt(err_evt), .o_sts_evt(sts_evt)
  );

  // ----------
  // tasks
  // ----------
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs <= '{read: !w, write: w, address: {a, 2'b00}, writedata: {24'h000000, d},
               byteenable: 4'hF};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata[7:0];
    if (n >= 50) err_count++;
    i_avs <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk8(q & m, e & m);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------
  // tests
  // ----------
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #(25 * 20000);
    err_count++;
    wrap_up;
  end
  initial begin
    logic [7:0] acc;
    logic [7:0] q;
    int         i;
    int         n;
    i_resetn = 1'b0;
    i_pll_locked = 1'b0;
    i_avs = '0;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    rc(SF, 8'h00, 8'hFF);
    rc(EF, 8'h00, 8'hFF);
    rc(SE, 8'h00, 8'hFF);
    rc(EE, 8'h00, 8'hFF);
    rc(12'h000, 8'h00, 8'hFF);
    wr(SE, 8'hFF);
    rc(SE, 8'h7F, 8'hFF);
    wr(EE, 8'hFF);
    rc(EE, 8'h9F, 8'hFF);
    $display("done: registers");
    wr(SE, 8'h02);
    acc = 8'h00;
    for (i = 0; i < 6; i++) begin
      u_usb_host_model.pulse(6'h01 << i, 4'h0);
      acc = acc | ERR_BIT[i];
      rc(EF, acc, 8'hFF);
    end
    @(negedge i_clk_sys);
    chk8({7'h00, o_usb_irq}, 8'h01);
    rc(SF, 8'h02, 8'h02);
    wr(EF, 8'hFF);
    rc(EF, 8'h9F, 8'hFF);
    wr(SF, 8'h00);
    rc(SF, 8'h02, 8'h02);
    wr(EF, 8'h00);
    rc(SF, 8'h00, 8'h02);
    wr(EE, 8'h04);
    u_usb_host_model.pulse(6'h01, 4'h0);
    rc(SF, 8'h00, 8'h02);
    u_usb_host_model.pulse(6'h04, 4'h0);
    rc(SF, 8'h02, 8'h02);
    wr(EF, 8'h00);
    $display("done: errors");
    for (i = 0; i < 4; i++) begin
      wr(SE, STS_BIT[i]);
      u_usb_host_model.pulse(6'h00, 4'h1 << i);
      @(negedge i_clk_sys);
      chk8({7'h00, o_usb_irq}, 8'h01);
      wr(SE, 8'h00);
      @(negedge i_clk_sys);
      chk8({7'h00, o_usb_irq}, 8'h00);
      rc(SF, STS_BIT[i], STS_BIT[i]);
      wr(SF, 8'h00);
    end
    $display("done: status");
    repeat (IDLE_N + 10) @(posedge i_clk_sys);
    u_usb_host_model.traffic(8);
    rc(SF, 8'h04, 8'h04);
    wr(SF, 8'h00);
    u_usb_host_model.traffic(20);
    rc(SF, 8'h00, 8'h14);
    repeat (IDLE_N + 10) @(posedge i_clk_sys);
    rc(SF, 8'h10, 8'h14);
    u_usb_host_model.traffic(8);
    rc(SF, 8'h04, 8'h04);
    $display("done: activity");
    wr(SF, 8'h00);
    repeat (IDLE_N + 10) @(posedge i_clk_sys);
    wr(CT, 8'h02);
    repeat (2) @(negedge i_clk_sys);
    chk8({6'h00, o_suspend, o_engine_run}, 8'h02);
    u_usb_host_model.pulse(6'h3F, 4'hF);
    rc(EF, 8'h00, 8'hFF);
    u_usb_host_model.traffic(4);
    rc(SF, 8'h04, 8'h6D);
    wr(SF, 8'h00);
    rc(SF, 8'h04, 8'h04);
    wr(CT, 8'h01);
    repeat (20) @(negedge i_clk_sys);
    chk8({6'h00, o_suspend, o_engine_run}, 8'h00);
    wr(SF, 8'h00);
    rc(SF, 8'h04, 8'h04);
    i_pll_locked <= 1'b1;
    n = 0;
    do begin
      wr(SF, 8'h00);
      bus(1'b0, SF, 8'h00, q);
      n++;
    end while (q[2] !== 1'b0 && n < 30);
    chk8(q & 8'h04, 8'h00);
    chk8({7'h00, o_engine_run}, 8'h01);
    $display("done: suspend");
    wrap_up;
  end
endmodule

// File: bench/usb_irq_monitor.sv
/* checker on the ports of the usb interrupt flag logic.
   assumes it is bound into every instance of that module. */
`timescale 1ns/1ps
module usb_irq_monitor
  import usb_irq_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
) (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire avs_req_t    i_avs,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire err_evt_t    i_err_evt,
  input wire logic        o_usb_irq,
  input wire logic        o_engine_run,
  input wire logic        o_token_reject,
  input wire logic        o_suspend
);
  // ----------
  // port checks
  // ----------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire logic en_off;
  assign en_off = i_avs.write && !o_avs_waitrequest && i_avs.byteenable[0]
    && i_avs.address == {IDX_STATUS_ENABLES, 2'b00} && i_avs.writedata[7:0] == 8'h00;

  property p_wait_ans; (i_avs.read || i_avs.write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("bus not answered");
  property p_hi_zero; !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_reject; i_err_evt.token_crc && o_engine_run |=> o_token_reject; endproperty
  a_reject: assert property (p_reject) else $error("token not rejected");
  property p_reject_src; o_token_reject |-> $past(i_err_evt.token_crc); endproperty
  a_reject_src: assert property (p_reject_src) else $error("stray reject");
  property p_susp_halt; o_suspend ##1 o_suspend |-> !o_engine_run; endproperty
  a_susp_halt: assert property (p_susp_halt) else $error("engine runs suspended");
  property p_wake_sync; $fell(o_suspend) |-> !o_engine_run [*3]; endproperty
  a_wake_sync: assert property (p_wake_sync) else $error("no wake sync");
  property p_run_rise; $rose(o_engine_run) |-> !$past(o_suspend, 4); endproperty
  a_run_rise: assert property (p_run_rise) else $error("run too soon");
  property p_irq_off; en_off |=> !o_usb_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not gated");
endmodule
bind usb_interrupt_flag_logic usb_irq_monitor #(.IDLE_COUNT(IDLE_COUNT)) u_usb_irq_monitor (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_err_evt(i_err_evt), .o_usb_irq(o_usb_irq), .o_engine_run(o_engine_run),
  .o_token_reject(o_token_reject), .o_suspend(o_suspend)
);

// File: src/usb_idle_timer.sv
/*
  Idle timer: counts cycles with no line activity while the engine runs
  and gives one pulse when the bus has stayed idle for the full time.
  Assumes i_activity is already synchronised to the system clock.
*/
`timescale 1ns/1ps
module usb_idle_timer
  import usb_irq_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  input  wire logic i_run,
  input  wire logic i_activity,
  output logic      o_idle_pulse
);

  localparam int CNT_W = $clog2(IDLE_COUNT + 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             fired;
    logic             pulse;
  } idle_state_t;

  idle_state_t st;
  idle_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (!i_run || i_activity) begin
      next_st.count = '0;
      next_st.fired = 1'b0;
    end else if (!st.fired) begin
      if (st.count == CNT_W'(IDLE_COUNT - 1)) begin
        next_st.fired = 1'b1;
        next_st.pulse = 1'b1;
      end else begin
        next_st.count = st.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_idle_pulse = st.pulse;

endmodule

// File: src/usb_interrupt_flag_logic.sv
/*
  USB interrupt flag logic: status and error flags, their enables, the
  error summary, bus activity wake handling and the suspend sequencing,
  reached over an Avalon-MM slave with waitrequest.
  Assumes event pulses from the serial interface engine on the system
  clock, raw D+/D- and pll lock levels from outside the clock domain.
*/
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module usb_interrupt_flag_logic
  import usb_irq_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire avs_req_t    i_avs,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_line_dp,
  input  wire logic        i_line_dm,
  input  wire logic        i_pll_locked,
  input  wire err_evt_t    i_err_evt,
  input  wire sts_evt_t    i_sts_evt,
  output logic             o_usb_irq,
  output logic             o_engine_run,
  output logic             o_token_reject,
  output logic             o_suspend
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wait_req;
    logic [7:0] rdata;
    logic [7:0] sts_flags;
    logic [7:0] sts_en;
    logic [7:0] err_flags;
    logic [7:0] err_en;
    logic [7:0] ctl;
    pwr_t       pwr;
    logic [2:0] sync_cnt;
    logic [1:0] line_prev;
    logic [1:0] line_warm;
    logic       actv_armed;
    logic       engine_run;
    logic       irq;
    logic       token_reject;
  } flag_state_t;

  localparam flag_state_t STATE_RESET = '{
    wait_req:     1'b1,
    rdata:        8'h00,
    sts_flags:    STATUS_FLAGS_RESET,
    sts_en:       STATUS_ENABLES_RESET,
    err_flags:    ERROR_FLAGS_RESET,
    err_en:       ERROR_ENABLES_RESET,
    ctl:          CONTROL_RESET,
    pwr:          PWR_SYNC,
    sync_cnt:     3'h0,
    line_prev:    2'h0,
    line_warm:    2'h0,
    actv_armed:   1'b1,
    engine_run:   1'b0,
    irq:          1'b0,
    token_reject: 1'b0
  };

  flag_state_t st;
  flag_state_t next_st;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [11:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  typedef enum {
    SEL_NONE,
    SEL_STS_EN,
    SEL_ERR_EN,
    SEL_STS_FLAGS,
    SEL_ERR_FLAGS,
    SEL_CTL
  } reg_sel_t;

  function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
    reg_sel_t r;
    case (addr)
      reg_addr(IDX_STATUS_FLAGS):   r = SEL_STS_FLAGS;
      reg_addr(IDX_STATUS_ENABLES): r = SEL_STS_EN;
      reg_addr(IDX_ERROR_FLAGS):    r = SEL_ERR_FLAGS;
      reg_addr(IDX_ERROR_ENABLES):  r = SEL_ERR_EN;
      reg_addr(IDX_CONTROL):        r = SEL_CTL;
      default:                      r = SEL_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] sts_to_byte(input sts_evt_t s);
    logic [7:0] b;
    b                 = 8'h00;
    b[ST_FRAME_START] = s.frame_start;
    b[ST_STALL]       = s.stall_sent;
    b[ST_TRANS_DONE]  = s.transaction_done;
    b[ST_BUS_RESET]   = s.bus_reset;
    return b;
  endfunction

  function automatic logic [7:0] err_to_byte(input err_evt_t e);
    logic [7:0] b;
    b                = 8'h00;
    b[ER_STUFFING]   = e.bit_stuffing;
    b[ER_TURNAROUND] = e.turnaround;
    b[ER_BYTE_COUNT] = e.byte_count;
    b[ER_DATA_CRC]   = e.data_crc;
    b[ER_TOKEN_CRC]  = e.token_crc;
    b[ER_PACKET_ID]  = e.packet_id;
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // synchronisers and idle timer
  // ----------------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       idle_pulse;
  logic       line_change;
  logic       pll_locked;

  usb_line_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_async   ({i_pll_locked, i_line_dp, i_line_dm}),
    .o_sync    (pins_sync)
  );

  assign pll_locked  = pins_sync[2];
  assign line_change = (st.line_warm == 2'(LINE_WARM_CYCLES))
                       && (pins_sync[1:0] != st.line_prev);

  usb_idle_timer #(
    .IDLE_COUNT (IDLE_COUNT)
  ) u_idle (
    .i_clk_sys    (i_clk_sys),
    .i_resetn     (i_resetn),
    .i_run        (st.engine_run),
    .i_activity   (line_change),
    .o_idle_pulse (idle_pulse)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic       hit;
  logic       do_wr;
  logic       run;
  logic       suspend;
  logic       pll_wait;
  logic [7:0] wdata;
  logic [7:0] sts_set;
  logic [7:0] err_set;
  reg_sel_t   sel;

  always_comb begin
    next_st   = st;
    run       = st.pwr == PWR_RUN;
    suspend   = st.ctl[CTL_SUSPEND];
    pll_wait  = st.ctl[CTL_PLL_SOURCE] && !pll_locked;
    wdata     = i_avs.writedata[7:0];
    hit       = (i_avs.read || i_avs.write) && st.wait_req;
    do_wr     = i_avs.write && !st.wait_req && i_avs.byteenable[0];
    sts_set   = 8'h00;
    err_set   = 8'h00;
    sel       = decode_reg(i_avs.address);

    // --------------------------------------------------------------------
    // bus slave: one wait cycle, then accept
    // --------------------------------------------------------------------
    next_st.wait_req = !hit;
    if (hit && i_avs.read) begin
      case (sel)
        SEL_STS_FLAGS: next_st.rdata = st.sts_flags;
        SEL_STS_EN:    next_st.rdata = st.sts_en;
        SEL_ERR_FLAGS: next_st.rdata = st.err_flags;
        SEL_ERR_EN:    next_st.rdata = st.err_en;
        SEL_CTL:       next_st.rdata = st.ctl;
        default:       next_st.rdata = 8'h00;
      endcase
    end

    // --------------------------------------------------------------------
    // power sequencing after suspend
    // --------------------------------------------------------------------
    next_st.line_prev = pins_sync[1:0];
    if (st.line_warm != 2'(LINE_WARM_CYCLES)) begin
      next_st.line_warm = st.line_warm + 2'h1;
    end
    case (st.pwr)
      PWR_SUSPENDED: begin
        next_st.sync_cnt = 3'h0;
        if (!suspend) begin
          next_st.pwr = pll_wait ? PWR_WAIT_PLL : PWR_SYNC;
        end
      end
      PWR_WAIT_PLL: begin
        if (suspend) begin
          next_st.pwr = PWR_SUSPENDED;
        end else if (!pll_wait) begin
          next_st.pwr = PWR_SYNC;
        end
      end
      PWR_SYNC: begin
        if (suspend) begin
          next_st.pwr = PWR_SUSPENDED;
        end else if (st.sync_cnt == 3'(WAKE_SYNC_CYCLES - 1)) begin
          next_st.pwr = PWR_RUN;
        end else begin
          next_st.sync_cnt = st.sync_cnt + 3'h1;
        end
      end
      PWR_RUN: begin
        next_st.sync_cnt = 3'h0;
        if (suspend) begin
          next_st.pwr = PWR_SUSPENDED;
        end else if (pll_wait) begin
          next_st.pwr = PWR_WAIT_PLL;
        end
      end
      default: begin
        next_st.pwr = PWR_SUSPENDED;
      end
    endcase
    next_st.engine_run = next_st.pwr == PWR_RUN;

    // --------------------------------------------------------------------
    // events: only activity, and an idle pulse due from the last running cycle, are seen while the engine is stopped
    // --------------------------------------------------------------------
    if (run) begin
      sts_set = sts_to_byte(i_sts_evt);
      err_set = err_to_byte(i_err_evt);
    end
    sts_set[ST_IDLE]     = idle_pulse;
    sts_set[ST_ACTIVITY] = line_change && st.actv_armed;
    next_st.token_reject = run && i_err_evt.token_crc;

    // --------------------------------------------------------------------
    // register writes, set wins over clear
    // --------------------------------------------------------------------
    if (do_wr) begin
      case (sel)
        SEL_STS_FLAGS: begin
          next_st.sts_flags = wdata & STATUS_SW_MASK;
          if (!run) begin
            next_st.sts_flags[ST_ACTIVITY] = st.sts_flags[ST_ACTIVITY];
          end else if (st.sts_flags[ST_ACTIVITY] && !wdata[ST_ACTIVITY]) begin
            next_st.actv_armed = 1'b0;
          end
        end
        SEL_STS_EN: begin
          next_st.sts_en = wdata & STATUS_IMPL_MASK;
        end
        SEL_ERR_FLAGS: begin
          next_st.err_flags = st.err_flags & wdata;
        end
        SEL_ERR_EN: begin
          next_st.err_en = wdata & ERROR_IMPL_MASK;
        end
        SEL_CTL: begin
          next_st.ctl = wdata & CONTROL_MASK;
        end
        default: begin
          next_st.ctl = st.ctl;
        end
      endcase
    end
    if (idle_pulse) begin
      next_st.actv_armed = 1'b1;
    end

    // --------------------------------------------------------------------
    // flag merge, error summary and interrupt
    // --------------------------------------------------------------------
    next_st.err_flags = (next_st.err_flags | err_set) & ERROR_IMPL_MASK;
    next_st.sts_flags = (next_st.sts_flags | sts_set) & STATUS_SW_MASK;
    next_st.sts_flags[ST_ERR_SUMMARY] = |(next_st.err_flags & next_st.err_en);
    next_st.irq = |(next_st.sts_flags & next_st.sts_en);
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_avs_readdata    = {24'h000000, st.rdata};
  assign o_avs_waitrequest = st.wait_req;
  assign o_usb_irq         = st.irq;
  assign o_engine_run      = st.engine_run;
  assign o_token_reject    = st.token_reject;
  assign o_suspend         = st.ctl[CTL_SUSPEND];

endmodule

// File: src/usb_irq_pkg.sv
/*
  Shared constants and types of the USB interrupt flag logic: register
  indices, field positions, reset values, timing counts and carriers.
  Assumes a single 40 MHz system clock and a byte-addressed Avalon-MM bus
  on which every register takes one aligned 32-bit word.
*/
package usb_irq_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ     = 40000;
  localparam int IDLE_TIME_US     = 3000;
  localparam int IDLE_CYCLES      = (IDLE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int WAKE_SYNC_CYCLES = 4;
  localparam int LINE_WARM_CYCLES = 3;

  // ----------------------------------------------------------------------
  // register map (index, byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int         ADDR_W             = 14;
  localparam logic [11:0] IDX_STATUS_ENABLES = 12'hF36;
  localparam logic [11:0] IDX_ERROR_ENABLES  = 12'hF37;
  localparam logic [11:0] IDX_STATUS_FLAGS   = 12'hF62;
  localparam logic [11:0] IDX_ERROR_FLAGS    = 12'hF63;
  localparam logic [11:0] IDX_CONTROL        = 12'hF6D;

  // status flag and status enable fields
  localparam int ST_BUS_RESET   = 0;
  localparam int ST_ERR_SUMMARY = 1;
  localparam int ST_ACTIVITY    = 2;
  localparam int ST_TRANS_DONE  = 3;
  localparam int ST_IDLE        = 4;
  localparam int ST_STALL       = 5;
  localparam int ST_FRAME_START = 6;

  // error flag and error enable fields
  localparam int ER_PACKET_ID  = 0;
  localparam int ER_TOKEN_CRC  = 1;
  localparam int ER_DATA_CRC   = 2;
  localparam int ER_BYTE_COUNT = 3;
  localparam int ER_TURNAROUND = 4;
  localparam int ER_STUFFING   = 7;

  // control fields
  localparam int CTL_PLL_SOURCE = 0;
  localparam int CTL_SUSPEND    = 1;

  localparam logic [7:0] STATUS_IMPL_MASK = 8'h7F;
  localparam logic [7:0] STATUS_SW_MASK   = 8'h7D;
  localparam logic [7:0] ERROR_IMPL_MASK  = 8'h9F;
  localparam logic [7:0] CONTROL_MASK     = 8'h03;

  localparam logic [7:0] STATUS_FLAGS_RESET   = 8'h00;
  localparam logic [7:0] STATUS_ENABLES_RESET = 8'h00;
  localparam logic [7:0] ERROR_FLAGS_RESET    = 8'h00;
  localparam logic [7:0] ERROR_ENABLES_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET        = 8'h00;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PWR_SUSPENDED, PWR_WAIT_PLL, PWR_SYNC, PWR_RUN} pwr_t;

  typedef struct packed {
    logic bit_stuffing;
    logic turnaround;
    logic byte_count;
    logic data_crc;
    logic token_crc;
    logic packet_id;
  } err_evt_t;

  typedef struct packed {
    logic frame_start;
    logic stall_sent;
    logic transaction_done;
    logic bus_reset;
  } sts_evt_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } avs_req_t;

endpackage

// File: src/usb_line_sync.sv
/*
  Two-stage synchroniser for levels entering the system clock domain.
  Assumes nothing of its inputs; only the second stage leaves the module.
*/
`timescale 1ns/1ps
module usb_line_sync
  import usb_irq_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = i_async;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stage2;

endmodule
